// ==== shared/pts_pkg.sv ====
// Shared constants and carrier types for the PCS test and RX statistics block
`default_nettype none
package pts_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MISCNT = 8'h08;
  localparam logic [7:0] OFF_MAXLEN = 8'h0c;
  // Control register fields
  localparam int CTRL_RXTEST_BIT = 0;
  localparam int CTRL_TXTEST_BIT = 1;
  localparam int CTRL_REPLACE_BIT = 2;
  localparam int CTRL_VALUE_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_ff07;
  // Status register fields
  localparam int STAT_SOS_BIT = 0;
  localparam int STAT_FOUR_BIT = 1;
  localparam int STAT_BIPV_BIT = 2;
  localparam int STAT_BIP_LSB = 8;
  // Frame length limits, in bytes
  localparam logic [13:0] MIN_FRAME = 14'h0040;
  localparam logic [13:0] MAXLEN_RST = 14'h05ee;
  // Histogram lower bounds; each bin ends one below the next bound
  localparam int NBIN = 11;
  localparam logic [13:0] BIN_LO [0:NBIN] = '{
    14'h0040, 14'h0041, 14'h0080, 14'h0100, 14'h0200, 14'h0400,
    14'h05ef, 14'h05f3, 14'h060d, 14'h0800, 14'h1000, 14'h2000};
  // Idle block before scrambling: control sync header, idle block type, zero payload
  localparam logic [1:0] SYNC_CTRL = 2'h2;
  localparam logic [7:0] IDLE_TYPE = 8'h1e;
  localparam logic [63:0] IDLE_PAYLOAD = {56'h0, IDLE_TYPE};
  localparam logic [57:0] SCR_SEED = 58'h3ff_ffff_ffff_ffff;
  // Active PCS lane counts for each attachment
  localparam logic [4:0] LANES_FOUR = 5'h04;
  localparam logic [4:0] LANES_TEN = 5'h0a;

  typedef struct packed {
    logic endValid;
    logic [13:0] len;
    logic fcsErr;
    logic otherErr;
  } pts_pkt_s;

  typedef struct packed {
    logic [7:0] totalBytes;
    logic [3:0] totalPackets;
    logic [13:0] goodBytes;
    logic goodPacket;
    logic crcFail;
    logic [NBIN-1:0] sizeBin;
  } pts_stat_s;
endpackage : pts_pkg
`default_nettype wire

// ==== hdl/pts_stat_top.sv ====
// PCS test pattern, marker parity override and RX statistics increments
`timescale 1ns/10ps
`default_nettype none
module pts_stat_top #(
  parameter int NBLK = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [pts_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pts_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Static lane mode pin
  input wire logic four_lane_select,
  output logic [4:0] activeLanes,
  // Receive PCS side
  input wire logic rxSignalOsIn,
  input wire logic [NBLK*66-1:0] rxBlocks,
  input wire logic rxMarkerStrobe,
  input wire logic [7:0] rxMarkerByteIn,
  input wire logic rxLaneAligned,
  output logic rx_signal_ordered_set_seen,
  output logic [2:0] rxTestMismatch,
  output logic [7:0] rx_marker_parity_byte,
  output logic rx_marker_parity_byte_valid,
  // Receive MAC side
  input wire logic [7:0] rxBytesIn,
  input wire pts_pkg::pts_pkt_s rxPkt,
  output var pts_pkg::pts_stat_s rxStat,
  // Transmit PCS side
  input wire logic txMarkerStrobe,
  input wire logic [7:0] txMarkerByteIn,
  output logic [7:0] txMarkerByteOut,
  output logic txMarkerValid,
  output logic [NBLK*66-1:0] txTestBlocks,
  output logic txTestValid
);
  logic [31:0] ctrl;
  logic [13:0] maxLen;
  logic [31:0] misCount;
  logic sosSticky;
  logic [2:0] fourSync;
  logic fourStable;
  logic [pts_pkg::ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic awHeld;
  logic wHeld;
  logic doWrite;
  logic [31:0] wMask;
  logic rxTestEn;
  logic txTestEn;
  logic replaceEn;
  logic [7:0] replaceValue;
  logic [2:0] next_mismatch;
  logic [57:0] txScr;
  logic [57:0] next_txScr;
  logic [NBLK*66-1:0] next_txBlocks;
  logic [pts_pkg::NBIN-1:0] binHit;
  logic pktGood;
  logic sosClear;
  logic misClear;

  assign rxTestEn = ctrl[pts_pkg::CTRL_RXTEST_BIT];
  assign txTestEn = ctrl[pts_pkg::CTRL_TXTEST_BIT];
  assign replaceEn = ctrl[pts_pkg::CTRL_REPLACE_BIT];
  assign replaceValue = ctrl[pts_pkg::CTRL_VALUE_LSB +: 8];
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
  assign sosClear = doWrite && awAddr == pts_pkg::OFF_STATUS && wStrb[0]
    && wData[pts_pkg::STAT_SOS_BIT];
  assign misClear = doWrite && awAddr == pts_pkg::OFF_MISCNT;

  // One 64-bit step of the self-synchronising scrambler, x^58 + x^39 + 1
  function automatic logic [121:0] scramble(input logic [57:0] st, input logic [63:0] d);
    logic [57:0] s;
    logic [63:0] q;
    s = st;
    q = '0;
    for (int i = 0; i < 64; i++) begin
      q[i] = d[i] ^ s[38] ^ s[57];
      s = {s[56:0], q[i]};
    end
    return {s, q};
  endfunction : scramble

  // AXI write channel: address and data taken in either order
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!awHeld && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!wHeld && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awAddr)
          pts_pkg::OFF_CTRL, pts_pkg::OFF_STATUS, pts_pkg::OFF_MISCNT, pts_pkg::OFF_MAXLEN: begin
            s_axi_bresp <= 2'h0;
          end
          default: begin
            s_axi_bresp <= 2'h3;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control and max length registers honour byte strobes; a miscount write loads the current mismatch count (zero if checker off), ignoring strobes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl <= pts_pkg::CTRL_RST;
      maxLen <= pts_pkg::MAXLEN_RST;
    end else if (doWrite) begin
      if (awAddr == pts_pkg::OFF_CTRL) begin
        ctrl <= ((ctrl & ~wMask) | (wData & wMask)) & pts_pkg::CTRL_MASK;
      end
      if (awAddr == pts_pkg::OFF_MAXLEN) begin
        maxLen <= (maxLen & ~wMask[13:0]) | (wData[13:0] & wMask[13:0]);
      end
    end
  end

  // AXI read channel
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        pts_pkg::OFF_CTRL: begin
          s_axi_rdata <= ctrl;
        end
        pts_pkg::OFF_STATUS: begin
          s_axi_rdata <= {16'h0, rx_marker_parity_byte, 5'h0, rx_marker_parity_byte_valid,
            fourStable, sosSticky};
        end
        pts_pkg::OFF_MISCNT: begin
          s_axi_rdata <= misCount;
        end
        pts_pkg::OFF_MAXLEN: begin
          s_axi_rdata <= {18'h0, maxLen};
        end
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= 2'h3;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Lane mode pin is asynchronous; accept a level once the last two stages agree
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fourSync <= '0;
      fourStable <= 1'b0;
      activeLanes <= pts_pkg::LANES_TEN;
    end else begin
      fourSync <= {fourSync[1:0], four_lane_select};
      if (fourSync[1] == fourSync[2]) begin
        fourStable <= fourSync[2];
      end
      activeLanes <= fourStable ? pts_pkg::LANES_FOUR : pts_pkg::LANES_TEN;
    end
  end

  // Signal ordered set: one-cycle pulse out, sticky copy for software; set beats clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_signal_ordered_set_seen <= 1'b0;
      sosSticky <= 1'b0;
    end else begin
      rx_signal_ordered_set_seen <= rxSignalOsIn;
      if (rxSignalOsIn) begin
        sosSticky <= 1'b1;
      end else if (sosClear) begin
        sosSticky <= 1'b0;
      end
    end
  end

  // Test pattern checker: descrambled blocks that are not idle count as mismatches
  always_comb begin
    next_mismatch = '0;
    for (int b = 0; b < NBLK; b++) begin
      if (rxBlocks[b*66 +: 66] != {pts_pkg::IDLE_PAYLOAD, pts_pkg::SYNC_CTRL}) begin
        next_mismatch = next_mismatch + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxTestMismatch <= '0;
      misCount <= '0;
    end else begin
      rxTestMismatch <= rxTestEn ? next_mismatch : 3'h0;
      // Saturates rather than wraps so a long soak never reads as clean
      if (misClear) begin
        misCount <= rxTestEn ? {29'h0, next_mismatch} : 32'h0;
      end else if (rxTestEn) begin
        misCount <= (misCount > ~{29'h0, next_mismatch}) ? 32'hffff_ffff : misCount + {29'h0, next_mismatch};
      end
    end
  end

  // Received lane zero marker parity; valid until alignment is lost
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_marker_parity_byte <= '0;
      rx_marker_parity_byte_valid <= 1'b0;
    end else if (!rxLaneAligned) begin
      rx_marker_parity_byte_valid <= 1'b0;
    end else if (rxMarkerStrobe) begin
      rx_marker_parity_byte <= rxMarkerByteIn;
      rx_marker_parity_byte_valid <= 1'b1;
    end
  end

  // Transmit lane zero marker parity, replaced while override is on
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txMarkerByteOut <= '0;
      txMarkerValid <= 1'b0;
    end else begin
      txMarkerValid <= txMarkerStrobe;
      if (txMarkerStrobe) begin
        txMarkerByteOut <= replaceEn ? replaceValue : txMarkerByteIn;
      end
    end
  end

  // Test pattern generator: idle blocks through a running scrambler
  always_comb begin
    logic [121:0] step;
    step = '0;
    next_txScr = txScr;
    next_txBlocks = '0;
    for (int b = 0; b < NBLK; b++) begin
      step = scramble(next_txScr, pts_pkg::IDLE_PAYLOAD);
      next_txScr = step[121:64];
      next_txBlocks[b*66 +: 66] = {step[63:0], pts_pkg::SYNC_CTRL};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txScr <= pts_pkg::SCR_SEED;
      txTestBlocks <= '0;
      txTestValid <= 1'b0;
    end else begin
      txTestValid <= txTestEn;
      if (txTestEn) begin
        txScr <= next_txScr;
        txTestBlocks <= next_txBlocks;
      end else begin
        txTestBlocks <= '0;
      end
    end
  end

  // Size histogram: one comparator pair per bin
  genvar g;
  generate
    for (g = 0; g < pts_pkg::NBIN; g++) begin : gBin
      assign binHit[g] = rxPkt.len >= pts_pkg::BIN_LO[g] && rxPkt.len < pts_pkg::BIN_LO[g+1];
    end
  endgenerate

  assign pktGood = rxPkt.endValid && !rxPkt.fcsErr && !rxPkt.otherErr;

  // Increments are registered: zero unless their event occurred on the cycle before
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxStat <= '0;
    end else begin
      rxStat.totalBytes <= rxBytesIn;
      rxStat.totalPackets <= {3'h0, rxPkt.endValid};
      rxStat.goodBytes <= pktGood ? rxPkt.len : 14'h0;
      rxStat.goodPacket <= pktGood;
      rxStat.crcFail <= rxPkt.endValid && rxPkt.fcsErr && rxPkt.len >= pts_pkg::MIN_FRAME
        && rxPkt.len <= maxLen;
      rxStat.sizeBin <= rxPkt.endValid ? binHit : '0;
    end
  end
endmodule : pts_stat_top
`default_nettype wire

// ==== dv/pts_stat_monitor.sv ====
// Property checker bound to the PCS test and RX statistics block
`timescale 1ns/10ps
`default_nettype none
module pts_stat_monitor #(
  parameter int NBLK = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // PCS side
  input wire logic four_lane_select,
  input wire logic [4:0] activeLanes,
  input wire logic rxSignalOsIn,
  input wire logic rx_signal_ordered_set_seen,
  input wire logic [NBLK*66-1:0] rxBlocks,
  input wire logic [2:0] rxTestMismatch,
  input wire logic rxMarkerStrobe,
  input wire logic [7:0] rxMarkerByteIn,
  input wire logic rxLaneAligned,
  input wire logic [7:0] rx_marker_parity_byte,
  input wire logic rx_marker_parity_byte_valid,
  input wire logic [NBLK*66-1:0] txTestBlocks,
  input wire logic txTestValid,
  // MAC side
  input wire pts_pkg::pts_pkt_s rxPkt,
  input wire pts_pkg::pts_stat_s rxStat
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  function automatic logic [2:0] badOf(input logic [NBLK*66-1:0] b);
    badOf = '0;
    for (int i = 0; i < NBLK; i++) badOf += 3'(b[i*66+:66] != {pts_pkg::IDLE_PAYLOAD, pts_pkg::SYNC_CTRL});
  endfunction : badOf
  function automatic logic [10:0] binOf(input logic [13:0] n);
    for (int i = 0; i < 11; i++) binOf[i] = n >= pts_pkg::BIN_LO[i] && n < pts_pkg::BIN_LO[i+1];
  endfunction : binOf
  // Self-synchronising descrambler; the previous word supplies the 58-bit history
  function automatic logic [NBLK*64-1:0] payOf(input logic [NBLK*66-1:0] prev, input logic [NBLK*66-1:0] cur);
    logic [57:0] s;
    logic [NBLK*66-1:0] w;
    s = '0;
    payOf = '0;
    for (int p = 0; p < 2; p++) begin
      w = p ? cur : prev;
      for (int k = 0; k < NBLK; k++) begin
        for (int i = 0; i < 64; i++) begin
          payOf[k*64+i] = w[k*66+2+i] ^ s[38] ^ s[57];
          s = {s[56:0], w[k*66+2+i]};
        end
      end
    end
  endfunction : payOf
  property p_sos; rxSignalOsIn |=> rx_signal_ordered_set_seen; endproperty
  a_sos: assert property (p_sos) else $error("signal set flag missing");
  property p_mis; rxTestMismatch != 0 |-> rxTestMismatch == badOf($past(rxBlocks)); endproperty
  a_mis: assert property (p_mis) else $error("mismatch count wrong");
  property p_lane; $stable(four_lane_select) [*8] |-> activeLanes == (four_lane_select ? 5'h04 : 5'h0a); endproperty
  a_lane: assert property (p_lane) else $error("lane count wrong");
  property p_bip; rxMarkerStrobe && rxLaneAligned |=> rx_marker_parity_byte_valid
    && rx_marker_parity_byte == $past(rxMarkerByteIn); endproperty
  a_bip: assert property (p_bip) else $error("parity byte not captured");
  property p_bipOff; !rxLaneAligned && !rxMarkerStrobe |=> !rx_marker_parity_byte_valid; endproperty
  a_bipOff: assert property (p_bipOff) else $error("parity valid held");
  property p_txSync; txTestValid |-> txTestBlocks[1:0] == pts_pkg::SYNC_CTRL; endproperty
  a_txSync: assert property (p_txSync) else $error("test block header wrong");
  property p_txIdle; txTestValid && $past(txTestValid)
    |-> payOf($past(txTestBlocks), txTestBlocks) == {NBLK{pts_pkg::IDLE_PAYLOAD}}; endproperty
  a_txIdle: assert property (p_txIdle) else $error("test pattern not scrambled idle");
  property p_good; rxStat.goodBytes != 0 || rxStat.goodPacket
    |-> $past(rxPkt.endValid && !rxPkt.fcsErr && !rxPkt.otherErr); endproperty
  a_good: assert property (p_good) else $error("good count without good packet");
  property p_crc; rxStat.crcFail |-> $past(rxPkt.endValid && rxPkt.fcsErr && rxPkt.len >= 14'h0040); endproperty
  a_crc: assert property (p_crc) else $error("crc count wrong");
  property p_bins; rxStat.sizeBin == ($past(rxPkt.endValid) ? binOf($past(rxPkt.len)) : 11'h0); endproperty
  a_bins: assert property (p_bins) else $error("size bin wrong");
  property p_pkts; rxStat.totalPackets == {3'h0, $past(rxPkt.endValid)}; endproperty
  a_pkts: assert property (p_pkts) else $error("packet count wrong");
  c_crc: cover property (rxStat.crcFail);
  c_mis: cover property (rxTestMismatch == 3'(NBLK));
  c_tx: cover property (txTestValid);
endmodule : pts_stat_monitor
bind pts_stat_top pts_stat_monitor #(.NBLK(NBLK)) i_pts_stat_monitor (.clk_sys, .resetn, .four_lane_select,
  .activeLanes, .rxSignalOsIn, .rx_signal_ordered_set_seen, .rxBlocks, .rxTestMismatch, .rxMarkerStrobe,
  .rxMarkerByteIn, .rxLaneAligned, .rx_marker_parity_byte, .rx_marker_parity_byte_valid, .txTestBlocks,
  .txTestValid, .rxPkt, .rxStat);
`default_nettype wire

// ==== dv/pts_user_counters.sv ====
// User-side counters fed by the per-cycle statistics increments
`timescale 1ns/10ps
`default_nettype none
module pts_user_counters (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Increments
  input wire pts_pkg::pts_stat_s rxStat,
  // Totals
  output logic [31:0] pktTotal,
  output logic [31:0] crcTotal
);
  // Adds every cycle blindly, so a stray increment shows up in the totals
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pktTotal <= '0;
      crcTotal <= '0;
    end else begin
      pktTotal <= pktTotal + 32'(rxStat.totalPackets);
      crcTotal <= crcTotal + 32'(rxStat.crcFail);
    end
  end
endmodule : pts_user_counters
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the PCS test and RX statistics block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int NBLK = 4;
  localparam logic [65:0] IDLE = {56'h0, 8'h1e, 2'h2};
  localparam logic [13:0] LO [12] = '{14'h0040, 14'h0041, 14'h0080, 14'h0100, 14'h0200, 14'h0400,
    14'h05ef, 14'h05f3, 14'h060d, 14'h0800, 14'h1000, 14'h2000};
  logic clk_sys = 0, resetn = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, rxMarkerByteIn = '0, txMarkerByteIn = '0, rxBytesIn = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rnd = 32'h2743, pktTotal, crcTotal;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txMarkerValid;
  logic four_lane_select = 1, rxSignalOsIn = 0, rxMarkerStrobe = 0, rxLaneAligned = 1, txMarkerStrobe = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] rxTestMismatch;
  logic [7:0] txMarkerByteOut;
  logic [NBLK*66-1:0] rxBlocks = {NBLK{IDLE}};
  pts_pkg::pts_pkt_s rxPkt = '0;
  pts_pkg::pts_stat_s rxStat;
  logic [63:0] expQ [5][$];
  int failCount = 0, comparisons = 0, npkt = 0, ncrc = 0;
  pts_stat_top #(.NBLK(NBLK)) i_pts_stat_top (.*, .activeLanes(), .rx_signal_ordered_set_seen(),
    .rx_marker_parity_byte(), .rx_marker_parity_byte_valid(), .txTestBlocks(), .txTestValid());
  pts_user_counters i_pts_user_counters (.*);
  initial forever #2 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [10:0] binOf(input logic [13:0] n);
    for (int i = 0; i < 11; i++) binOf[i] = n >= LO[i] && n < LO[i+1];
  endfunction : binOf
  // An empty queue yields unknowns, so an unexpected result always mismatches
  function automatic logic [63:0] pop(input int k);
    return expQ[k].size() ? expQ[k].pop_front() : 'x;
  endfunction : pop
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] s);
    comparisons++;
    if (s !== e) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge clk_sys);
    expQ[0].push_back(64'(r));
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    while (aw || w) begin
      @(posedge clk_sys);
      if (aw && s_axi_awready) s_axi_awvalid <= 0;
      if (w && s_axi_wready) s_axi_wvalid <= 0;
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk_sys);
    expQ[1].push_back(64'(e));
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask : axr
  task automatic pkt(input logic [13:0] ln, input logic [13:0] mx, input logic frc);
    pts_pkg::pts_stat_s e;
    @(posedge clk_sys);
    rnd = lfsr(rnd);
    e = '0;
    rxPkt <= {1'b1, ln, rnd[0] | frc, rnd[1] & rnd[2]};
    rxBytesIn <= rnd[15:8];
    e.totalBytes = rnd[15:8];
    e.totalPackets = 4'h1;
    e.goodPacket = !(rnd[0] | frc) && !(rnd[1] & rnd[2]);
    e.goodBytes = e.goodPacket ? ln : '0;
    e.crcFail = (rnd[0] | frc) && ln >= 14'h0040 && ln <= mx;
    e.sizeBin = binOf(ln);
    expQ[2].push_back(64'(e));
    npkt++;
    ncrc += int'(e.crcFail);
  endtask : pkt
  task automatic blk(input int n, input logic en);
    logic [NBLK*66-1:0] b;
    b = {NBLK{IDLE}};
    @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      b[i*66+:66] = {rnd, rnd, 2'b01};
    end
    rxBlocks <= b;
    if (en && n != 0) expQ[3].push_back(64'(n));
  endtask : blk
  task automatic finishTest();
    foreach (expQ[k]) if (expQ[k].size() != 0) cmp("pending results", 64'h0, 64'(expQ[k].size()));
    $display("comparisons %0d failures %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finishTest
  always @(posedge clk_sys) if (resetn) begin
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", pop(0), 64'(s_axi_bresp));
    if (s_axi_rvalid && s_axi_rready) cmp("rdata", pop(1), {30'h0, s_axi_rresp, s_axi_rdata});
    if (rxStat.totalPackets !== 0) cmp("rxStat", pop(2), 64'(rxStat));
    if (rxTestMismatch !== 0) cmp("mismatch", pop(3), 64'(rxTestMismatch));
    if (txMarkerValid !== 0) cmp("txMarker", pop(4), 64'(txMarkerByteOut));
  end
  // The tests need well under two thousand cycles; this leaves ample room for slow answers
  initial begin
    repeat (20000) @(posedge clk_sys);
    failCount++;
    finishTest();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1;
    @(posedge clk_sys);
    axr(pts_pkg::OFF_CTRL, 34'h0);
    axr(pts_pkg::OFF_MAXLEN, 34'h5ee);
    axr(8'h40, 34'h3_0000_0000);
    axw(8'h40, rnd, 2'b11);
    rnd = lfsr(rnd);
    axw(pts_pkg::OFF_CTRL, rnd, 2'b00);
    axr(pts_pkg::OFF_CTRL, 34'(rnd & 32'h0000_ff07));
    $display("test registers done");
    axr(pts_pkg::OFF_STATUS, 34'h2);
    @(posedge clk_sys);
    {rxSignalOsIn, rxMarkerStrobe, rxMarkerByteIn} <= {2'b11, 8'ha5};
    @(posedge clk_sys);
    {rxSignalOsIn, rxMarkerStrobe} <= 2'b00;
    axr(pts_pkg::OFF_STATUS, 34'ha507);
    axw(pts_pkg::OFF_STATUS, 32'h1, 2'b00);
    four_lane_select <= 0;
    repeat (8) @(posedge clk_sys);
    axr(pts_pkg::OFF_STATUS, 34'ha504);
    rxLaneAligned <= 0;
    axr(pts_pkg::OFF_STATUS, 34'ha500);
    $display("test status done");
    for (int r = 0; r < 2; r++) begin
      axw(pts_pkg::OFF_CTRL, 32'hc302 | 32'(r << 2), 2'b00);
      @(posedge clk_sys);
      rnd = lfsr(rnd);
      {txMarkerStrobe, txMarkerByteIn} <= {1'b1, rnd[7:0]};
      expQ[4].push_back(64'(r ? 8'hc3 : rnd[7:0]));
      @(posedge clk_sys);
      txMarkerStrobe <= 0;
    end
    $display("test marker override done");
    for (int e = 1; e >= 0; e--) begin
      axw(pts_pkg::OFF_CTRL, 32'(e), 2'b00);
      for (int n = 0; n <= NBLK; n++) blk(n, e[0]);
      blk(0, 0);
    end
    axr(pts_pkg::OFF_MISCNT, 34'(NBLK * (NBLK + 1) / 2));
    axw(pts_pkg::OFF_MISCNT, 32'h0, 2'b00);
    axr(pts_pkg::OFF_MISCNT, 34'h0);
    $display("test pattern check done");
    foreach (LO[i]) begin
      pkt(LO[i] - 14'h1, 14'h05ee, 0);
      pkt(LO[i], 14'h05ee, 0);
    end
    @(posedge clk_sys);
    {rxPkt, rxBytesIn} <= '0;
    axw(pts_pkg::OFF_MAXLEN, 32'h64, 2'b00);
    pkt(14'h64, 14'h64, 1);
    pkt(14'h65, 14'h64, 1);
    @(posedge clk_sys);
    {rxPkt, rxBytesIn} <= '0;
    repeat (2) @(posedge clk_sys);
    cmp("pktTotal", 64'(npkt), 64'(pktTotal));
    cmp("crcTotal", 64'(ncrc), 64'(crcTotal));
    $display("test statistics done");
    finishTest();
  end
endmodule : tb_top
`default_nettype wire
